// ===== verilog/svw_pkg.sv
// Constants, timing counts and carrier types of the supervisor watchdog.
package svw_pkg;

   // Timebase and documented times.
   localparam longint unsigned CLK_HZ          = 64'h0000_0000_02FA_F080;
   localparam longint unsigned MS_PER_S        = 64'h0000_0000_0000_03E8;
   localparam longint unsigned NS_PER_S        = 64'h0000_0000_3B9A_CA00;
   localparam longint unsigned HOLD_TIME_MS    = 64'h0000_0000_0000_00C8;
   localparam longint unsigned WD_TIME_MS      = 64'h0000_0000_0000_0640;
   localparam longint unsigned MANUAL_DELAY_NS = 64'h0000_0000_0000_02EE;

   // Cycle counts derived from the times at the timebase rate.
   localparam longint unsigned HOLD_CYCLES_DEF =
      HOLD_TIME_MS * CLK_HZ / MS_PER_S;
   localparam longint unsigned WD_CYCLES_DEF   =
      WD_TIME_MS * CLK_HZ / MS_PER_S;
   // A longest time rounds down.
   localparam longint unsigned MANUAL_DELAY_CYC =
      MANUAL_DELAY_NS * CLK_HZ / NS_PER_S;

   // Counter width covers the watchdog period.
   localparam int CNT_W = 32'h0000_001B;

   // Output values during and right after reset.
   localparam logic RESET_N_RST = 1'h0;
   localparam logic WDO_N_RST   = 1'h1;
   localparam logic PFW_N_RST   = 1'h1;

   // Comparator results as seen by the logic.
   typedef struct packed {
      logic supply_low;
      logic backup_dominant;
      logic power_fail_sense;
   } svw_sense_t;

   typedef enum logic [2:0] {
      ST_ASSERT = 3'h1,
      ST_HOLD   = 3'h2,
      ST_RUN    = 3'h4
   } svw_state_t;

endpackage

// ===== verilog/svw_supervisor.sv
// Reset supervisor with hold timer, watchdog and power-fail warning.
`timescale 1ns/10ps
module svw_supervisor
#(
   parameter logic [svw_pkg::CNT_W-1:0] HOLD_CYCLES =
      svw_pkg::CNT_W'(svw_pkg::HOLD_CYCLES_DEF),
   parameter logic [svw_pkg::CNT_W-1:0] WD_CYCLES   =
      svw_pkg::CNT_W'(svw_pkg::WD_CYCLES_DEF)
)
(
   // Clock and reset.
   input  wire logic               clk_sys_in,
   input  wire logic               resetn_in,
   // Comparator and processor inputs.
   input  wire svw_pkg::svw_sense_t sense_in,
   input  wire logic               manual_reset_request_n_in,
   input  wire logic               watchdog_kick_in,
   // Outputs to the processor.
   output logic                    reset_n_out,
   output logic                    reset_out,
   output logic                    watchdog_expired_n_out,
   output logic                    power_fail_warning_n_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.

   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge clk_sys_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         rst_meta_ff <= 1'h0;
         rst_n_ff    <= 1'h0;
      end
      else
      begin
         rst_meta_ff <= 1'h1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset state machine and hold counter.

   svw_pkg::svw_state_t         state_ff;
   svw_pkg::svw_state_t         nxt_state;
   logic [svw_pkg::CNT_W-1:0]   hold_cnt_ff;
   logic                        reset_n_ff;
   logic                        cause;

   // Watchdog expiry is deliberately absent here; only the manual input
   // can carry it back in.
   assign cause = sense_in.supply_low | ~manual_reset_request_n_in;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         svw_pkg::ST_ASSERT:
         begin
            if (!cause)
               nxt_state = svw_pkg::ST_HOLD;
         end
         svw_pkg::ST_HOLD:
         begin
            if (cause)
               nxt_state = svw_pkg::ST_ASSERT;
            else if (hold_cnt_ff == HOLD_CYCLES - 1'h1)
               nxt_state = svw_pkg::ST_RUN;
         end
         svw_pkg::ST_RUN:
         begin
            if (cause)
               nxt_state = svw_pkg::ST_ASSERT;
         end
         default:
         begin
            nxt_state = svw_pkg::ST_ASSERT;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         state_ff <= svw_pkg::ST_ASSERT;
      else
         state_ff <= nxt_state;
   end

   // The count restarts from zero each time the hold is entered.
   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         hold_cnt_ff <= '0;
      else if (state_ff != svw_pkg::ST_HOLD)
         hold_cnt_ff <= '0;
      else
         hold_cnt_ff <= hold_cnt_ff + 1'h1;
   end

   // The output flop follows the next state so a request shows one cycle
   // after it is sampled, far inside the allowed delay.
   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         reset_n_ff <= svw_pkg::RESET_N_RST;
      else
         reset_n_ff <= (nxt_state == svw_pkg::ST_RUN);
   end

   assign reset_n_out = reset_n_ff;
   assign reset_out   = ~reset_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog.

   logic                        kick_prev_ff;
   logic                        kick_edge;
   logic [svw_pkg::CNT_W-1:0]   wd_cnt_ff;
   logic                        wdo_n_ff;

   // Inputs are synchronous, so every level change is one clean edge and
   // any pulse long enough to be sampled restarts the count.
   assign kick_edge = watchdog_kick_in ^ kick_prev_ff;

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         kick_prev_ff <= 1'h0;
      else
         kick_prev_ff <= watchdog_kick_in;
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         wd_cnt_ff <= '0;
      else if (kick_edge || sense_in.supply_low)
         wd_cnt_ff <= '0;
      else if (wd_cnt_ff != WD_CYCLES - 1'h1)
         wd_cnt_ff <= wd_cnt_ff + 1'h1;
   end

   // Expiry holds until the next kick edge or a supply-low event.
   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         wdo_n_ff <= svw_pkg::WDO_N_RST;
      else if (kick_edge || sense_in.supply_low)
         wdo_n_ff <= 1'h1;
      else if (wd_cnt_ff == WD_CYCLES - 1'h1)
         wdo_n_ff <= 1'h0;
   end

   assign watchdog_expired_n_out = wdo_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Power-fail warning, independent of reset and watchdog.

   logic pfw_n_ff;

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         pfw_n_ff <= svw_pkg::PFW_N_RST;
      else if (sense_in.backup_dominant)
         pfw_n_ff <= 1'h0;
      else
         pfw_n_ff <= sense_in.power_fail_sense;
   end

   assign power_fail_warning_n_out = pfw_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   localparam int MD_MAX = int'(svw_pkg::MANUAL_DELAY_CYC);

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_ff);

   property p_supply_low_reset;
      sense_in.supply_low |=> !reset_n_out && reset_out;
   endproperty
   a_supply_low_reset: assert property (p_supply_low_reset)
      else $error("Reset released while supply is low.");

   property p_hold_release;
      $rose(reset_n_out) |->
         $past(hold_cnt_ff) == HOLD_CYCLES - 1'h1 &&
         $past(state_ff) == svw_pkg::ST_HOLD;
   endproperty
   a_hold_release: assert property (p_hold_release)
      else $error("Reset released before the full hold period.");

   property p_manual_hold;
      $rose(manual_reset_request_n_in) && !sense_in.supply_low |=>
         !reset_n_out [*8];
   endproperty
   a_manual_hold: assert property (p_manual_hold)
      else $error("Manual reset not stretched after release.");

   property p_wd_expire;
      $fell(watchdog_expired_n_out) |->
         $past(wd_cnt_ff) == WD_CYCLES - 1'h1 &&
         !$past(kick_edge) && !$past(sense_in.supply_low);
   endproperty
   a_wd_expire: assert property (p_wd_expire)
      else $error("Watchdog expired at the wrong count.");

   property p_kick_restart;
      kick_edge |=> wd_cnt_ff == '0 && watchdog_expired_n_out;
   endproperty
   a_kick_restart: assert property (p_kick_restart)
      else $error("Kick edge did not restart the watchdog.");

   property p_wd_disabled;
      sense_in.supply_low |=> watchdog_expired_n_out && wd_cnt_ff == '0;
   endproperty
   a_wd_disabled: assert property (p_wd_disabled)
      else $error("Watchdog active while supply is low.");

   property p_pf_follow;
      !sense_in.backup_dominant |=>
         power_fail_warning_n_out == $past(sense_in.power_fail_sense);
   endproperty
   a_pf_follow: assert property (p_pf_follow)
      else $error("Power-fail warning does not follow comparator.");

   property p_pf_forced;
      sense_in.backup_dominant |=> !power_fail_warning_n_out;
   endproperty
   a_pf_forced: assert property (p_pf_forced)
      else $error("Power-fail warning not forced low.");

   property p_manual_delay;
      !manual_reset_request_n_in |-> ##[1:MD_MAX] !reset_n_out;
   endproperty
   a_manual_delay: assert property (p_manual_delay)
      else $error("Manual request too slow to reach reset.");

   property p_complement;
      reset_out == !reset_n_out;
   endproperty
   a_complement: assert property (p_complement)
      else $error("Reset outputs are not complementary.");

   property p_wdo_no_reset;
      reset_n_out && !cause |=> reset_n_out;
   endproperty
   a_wdo_no_reset: assert property (p_wdo_no_reset)
      else $error("Reset asserted without supply or manual cause.");

   property p_wd_reset_hold;
      $fell(reset_n_out) ##1 !cause |-> !reset_n_out [*8];
   endproperty
   a_wd_reset_hold: assert property (p_wd_reset_hold)
      else $error("Reset pulse shorter than the hold period.");

endmodule

// ===== sim/svw_cpu_model.sv
// Behavioural model of the supervised processor that kicks the watchdog.
`timescale 1ns/10ps
module svw_cpu_model
#(
   parameter int GAP = 8
)
(
   // Clock and controls.
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic kick_en_in,
   // Kick line.
   output logic      kick_out
);
   int cnt;

   initial kick_out = 1'h0;
   initial cnt = 0;

   // A processor held in reset runs no code, so it cannot kick then.
   always @(posedge clk_in)
   begin
      if (reset_n_in && kick_en_in)
      begin
         cnt = (cnt + 1) % GAP;
         if (cnt == 0)
            kick_out <= #1 ~kick_out;
      end
   end
endmodule

// ===== sim/tb_svw_supervisor.sv
// Self-checking testbench of the supervisor watchdog.
`timescale 1ns/10ps
module tb_svw_supervisor;
   localparam int HOLD = 16;
   localparam int WD   = 32;

   logic                clk_sys_in;
   logic                resetn_in;
   svw_pkg::svw_sense_t sense_in;
   logic                mr_n;
   logic                kick;
   logic                kick_en;
   logic                reset_n_out;
   logic                reset_out;
   logic                wdo_n;
   logic                pfw_n;
   int                  err_count;
   int                  checks_done;
   int                  n;

   svw_supervisor #(
      .HOLD_CYCLES(svw_pkg::CNT_W'(HOLD)),
      .WD_CYCLES  (svw_pkg::CNT_W'(WD))
   ) dut (
      .clk_sys_in               (clk_sys_in),
      .resetn_in                (resetn_in),
      .sense_in                 (sense_in),
      .manual_reset_request_n_in(mr_n),
      .watchdog_kick_in         (kick),
      .reset_n_out              (reset_n_out),
      .reset_out                (reset_out),
      .watchdog_expired_n_out   (wdo_n),
      .power_fail_warning_n_out (pfw_n)
   );

   svw_cpu_model cpu (
      .clk_in    (clk_sys_in),
      .reset_n_in(reset_n_out),
      .kick_en_in(kick_en),
      .kick_out  (kick)
   );

   always #10 clk_sys_in = ~clk_sys_in;

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // Bench inputs change 2 ns after the edge, after the model's kicks.
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys_in);
      #2;
   endtask

   // Sel 0 waits for reset release, sel 1 for watchdog expiry.
   task automatic wait_for(input int sel, output int c);
      c = 0;
      while ((sel == 0 ? reset_n_out !== 1'h1 : wdo_n !== 1'h0) && c < 400)
      begin
         cyc(1);
         c++;
      end
      if (c >= 400)
      begin
         err_count++;
         summarize();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_supply();
      kick_en = 1'h0;
      sense_in.supply_low = 1'h1;
      cyc(2);
      chk(2'h1, {reset_n_out, reset_out});
      cyc(WD + 10);
      chk(1'h1, wdo_n);
      sense_in.supply_low = 1'h0;
      wait_for(0, n);
      chk(HOLD + 1, 32'(n));
      kick_en = 1'h1;
   endtask

   task automatic t_manual();
      mr_n = 1'h0;
      cyc(2);
      chk(2'h1, {reset_n_out, reset_out});
      mr_n = 1'h1;
      cyc(5);
      chk(1'h0, reset_n_out);
      mr_n = 1'h0;
      cyc(1);
      mr_n = 1'h1;
      wait_for(0, n);
      chk(HOLD + 1, 32'(n));
   endtask

   task automatic t_watchdog();
      logic k;
      cyc(3 * WD);
      chk(2'h3, {wdo_n, reset_n_out});
      k = kick;
      n = 0;
      while (kick === k && n < 20)
      begin
         cyc(1);
         n++;
      end
      if (n >= 20)
      begin
         err_count++;
         summarize();
      end
      kick_en = 1'h0;
      wait_for(1, n);
      chk(WD + 1, 32'(n));
      chk(2'h2, {reset_n_out, reset_out});
      // Expiry wired back to the manual input is the only reset path.
      mr_n = wdo_n;
      cyc(3);
      chk(1'h0, reset_n_out);
      mr_n = 1'h1;
      wait_for(0, n);
      chk(HOLD + 1, 32'(n));
      kick_en = 1'h1;
      cyc(12);
      chk(1'h1, wdo_n);
   endtask

   task automatic t_power();
      logic [2:0] tab [4];
      logic       exp [4];
      tab = '{3'h0, 3'h1, 3'h3, 3'h5};
      exp = '{1'h0, 1'h1, 1'h0, 1'h1};
      for (int i = 0; i < 4; i++)
      begin
         sense_in = tab[i];
         cyc(2);
         chk(exp[i], pfw_n);
      end
      sense_in = 3'h1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys_in = 1'h0;
      resetn_in = 1'h0;
      sense_in = 3'h1;
      mr_n = 1'h1;
      kick_en = 1'h0;
      err_count = 0;
      checks_done = 0;
      cyc(12);
      chk(4'h7, {reset_n_out, reset_out, wdo_n, pfw_n});
      resetn_in = 1'h1;
      wait_for(0, n);
      // Two edges of release synchronising, one to leave the assert state.
      chk(HOLD + 3, 32'(n));
      kick_en = 1'h1;
      t_supply();
      t_manual();
      t_watchdog();
      t_power();
      summarize();
   end
endmodule
